/* File: src/adc_accum_unit.sv */
`timescale 1ns/1ns
module adc_accum_unit
    import adc_cfg_pkg::*;
#(
    parameter int data_w = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clear,
    input  wire logic              sample_done,
    input  wire logic              second_of_pair,
    input  wire logic              pair_mode,
    input  wire logic [2:0]        mode,
    input  wire logic [2:0]        right_shift,
    input  wire logic [9:0]        sample,
    input  wire logic [9:0]        prev_sample,
    output logic      [data_w-1:0] accum_ff,
    output logic      [data_w-1:0] filter_ff,
    output logic                   overflow_ff
);
    // ****************************************
    // accumulator and filter datapath
    // ****************************************
    logic [data_w:0]   nxt_sum;
    logic [data_w-1:0] lp_step;
    logic [data_w-1:0] nxt_accum;
    logic              ovf_event;
    logic              acc_mode;
    logic              lp_mode;

    assign acc_mode = (mode == mode_accumulate) || (mode == mode_average)
                    || (mode == mode_burst_avg);
    assign lp_mode  = (mode == mode_low_pass);
    // pair subtracts previous sample first, adds it back second
    assign nxt_sum  = (acc_mode && pair_mode)
        ? (second_of_pair ? {1'b0, accum_ff} + {{(data_w-9){1'b0}}, prev_sample}
                          : {1'b0, accum_ff} - {{(data_w-9){1'b0}}, prev_sample})
        : {1'b0, accum_ff} + {{(data_w-9){1'b0}}, sample};
    // unity gain low pass with time constant 2^shift
    assign lp_step    = (accum_ff >> right_shift);
    assign nxt_accum  = lp_mode ? (accum_ff - lp_step + {{(data_w-10){1'b0}}, sample})
                                : nxt_sum[data_w-1:0];
    // filter reads the updated sum so it never lags the accumulator by a sample
    assign ovf_event  = sample_done && acc_mode && nxt_sum[data_w];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accum_ff    <= '0;
            filter_ff   <= '0;
            overflow_ff <= 1'b0;
        end else if (clear) begin
            accum_ff    <= '0;
            // an overflow in the clearing cycle survives: set beats clear
            overflow_ff <= ovf_event;
        end else if (sample_done && mode != mode_basic) begin
            accum_ff    <= nxt_accum;
            filter_ff   <= nxt_accum >> right_shift;
            overflow_ff <= overflow_ff | ovf_event;
        end
    end
endmodule : adc_accum_unit

/* File: src/adc_cfg_pkg.sv */
package adc_cfg_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] sampling_ctrl_addr   = 12'h000;
    localparam logic [11:0] accumulate_ctrl_addr = 12'h004;
    localparam logic [11:0] status_addr          = 12'h008;
    localparam logic [11:0] accum_addr           = 12'h00c;
    localparam logic [11:0] prev_addr            = 12'h010;
    localparam logic [11:0] filter_addr          = 12'h014;
    localparam logic [11:0] result_addr          = 12'h018;
    localparam logic [11:0] precharge_time_addr  = 12'h01c;

    // ****************************************
    // field positions
    // ****************************************
    localparam int precharge_polarity_bit        = 7;
    localparam int inverted_precharge_enable_bit = 6;
    localparam int guard_ring_polarity_bit       = 5;
    localparam int double_sample_enable_bit      = 0;
    localparam int previous_sample_source_bit    = 7;
    localparam int accum_right_shift_lsb         = 4;
    localparam int accumulator_clear_bit         = 3;
    localparam int operating_mode_lsb            = 0;

    localparam logic [7:0] sampling_ctrl_mask   = 8'he1;
    localparam logic [7:0] sampling_ctrl_reset  = 8'h00;
    localparam logic [7:0] accumulate_ctrl_reset = 8'h00;
    localparam logic [7:0] precharge_time_reset = 8'h00;

    localparam logic [2:0] right_shift_max = 3'h5;

    typedef enum logic [2:0] {
        mode_basic      = 3'h0,
        mode_accumulate = 3'h1,
        mode_average    = 3'h2,
        mode_burst_avg  = 3'h3,
        mode_low_pass   = 3'h4
    } operating_mode_t;
endpackage : adc_cfg_pkg

/* File: src/adc_precharge_accum_config.sv */
`timescale 1ns/1ns
// Behaviour
// - precharge polarity sets pin and hold levels
// - inverted precharge flips second cycle polarity
// - no inversion keeps configured polarities both cycles
// - guard ring starts at guard polarity level
// - double sample enable selects paired sequence
// - low pass constant is two to shift
// - pair: subtract then add previous sample
// - clear bit clears accumulator, flag, counter
// - mode field codes, upper codes reserved
// - threshold computed after both pair conversions
module adc_precharge_accum_config
    import adc_cfg_pkg::*;
#(
    parameter int data_w = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        conv_start,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conversion_result,
    output logic             precharge_active,
    output logic             pin_to_avdd,
    output logic             pin_to_vss,
    output logic             hold_capacitor_to_avdd,
    output logic             hold_capacitor_to_vss,
    output logic             guard_ring_level,
    output logic             threshold_calc_strobe,
    output logic             second_of_pair
);
    // ****************************************
    // registers
    // ****************************************
    logic [7:0]        sampling_ctrl_ff;
    logic [7:0]        accumulate_ctrl_ff;
    logic [7:0]        precharge_time_ff;
    logic [9:0]        result_ff;
    logic [data_w-1:0] previous_result_ff;
    logic              pair_ff;
    logic              clear_pend_ff;
    logic [7:0]        sample_count_ff;
    logic              precharge_active_ff;
    logic              threshold_strobe_ff;
    logic [data_w-1:0] accum_value;
    logic [data_w-1:0] filtered_value;
    logic              accumulator_overflow;

    // ****************************************
    // decode
    // ****************************************
    logic wr_en;
    logic wr_sampling;
    logic wr_accumulate;
    logic wr_ptime;
    logic nxt_pair;
    logic nxt_strobe;
    logic double_sample_enable;
    logic inverted_precharge_enable;
    logic precharge_polarity;
    logic guard_ring_polarity;
    logic previous_sample_source;
    logic [2:0] accum_right_shift;
    logic [2:0] operating_mode_select;
    logic invert_now;
    logic eff_pol;
    logic eff_guard;
    logic [7:0] acc_wdata;
    logic [2:0] shift_wr;
    logic [2:0] mode_wr;

    // no wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel && penable && pwrite;

    // ****************************************
    // write selects
    // ****************************************
    assign wr_sampling   = wr_en && (paddr == sampling_ctrl_addr);
    assign wr_accumulate = wr_en && (paddr == accumulate_ctrl_addr);
    assign wr_ptime      = wr_en && (paddr == precharge_time_addr);

    assign double_sample_enable      = sampling_ctrl_ff[double_sample_enable_bit];
    assign inverted_precharge_enable = sampling_ctrl_ff[inverted_precharge_enable_bit];
    assign precharge_polarity        = sampling_ctrl_ff[precharge_polarity_bit];
    assign guard_ring_polarity       = sampling_ctrl_ff[guard_ring_polarity_bit];
    assign previous_sample_source    = accumulate_ctrl_ff[previous_sample_source_bit];
    assign accum_right_shift         = accumulate_ctrl_ff[accum_right_shift_lsb +: 3];
    assign operating_mode_select     = accumulate_ctrl_ff[operating_mode_lsb +: 3];

    // reserved codes are refused; the old value stays
    assign shift_wr  = (pwdata[6:4] > right_shift_max) ? accum_right_shift : pwdata[6:4];
    assign mode_wr   = (pwdata[2:0] > mode_low_pass) ? operating_mode_select : pwdata[2:0];
    assign acc_wdata = {pwdata[7], shift_wr, pwdata[3], mode_wr};

    // inversion only in the second cycle of an enabled pair
    assign invert_now = double_sample_enable && inverted_precharge_enable && pair_ff;
    assign eff_pol    = precharge_polarity ^ invert_now;
    assign eff_guard  = guard_ring_polarity ^ invert_now;

    // pairing advances only while enabled; a single sample never pairs
    assign nxt_pair   = double_sample_enable ? !pair_ff : 1'b0;
    // threshold only after a single or the second of a pair
    assign nxt_strobe = conv_done && (!double_sample_enable || pair_ff);

    // zero precharge time leaves every switch open
    assign precharge_active       = precharge_active_ff;
    assign pin_to_avdd            = precharge_active_ff && eff_pol;
    assign pin_to_vss             = precharge_active_ff && !eff_pol;
    assign hold_capacitor_to_vss  = precharge_active_ff && eff_pol;
    assign hold_capacitor_to_avdd = precharge_active_ff && !eff_pol;
    assign guard_ring_level       = eff_guard;
    assign second_of_pair         = pair_ff;
    assign threshold_calc_strobe  = threshold_strobe_ff;

    // ****************************************
    // register writes
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sampling_ctrl_ff   <= sampling_ctrl_reset;
            accumulate_ctrl_ff <= accumulate_ctrl_reset;
            precharge_time_ff  <= precharge_time_reset;
        end else begin
            if (wr_sampling) begin
                sampling_ctrl_ff <= pwdata[7:0] & sampling_ctrl_mask;
            end
            // a write in the clearing cycle wins over the hardware clear
            if (wr_accumulate) begin
                accumulate_ctrl_ff <= acc_wdata;
            end else if (clear_pend_ff) begin
                accumulate_ctrl_ff[accumulator_clear_bit] <= 1'b0;
            end
            if (wr_ptime) begin
                precharge_time_ff <= pwdata[7:0];
            end
        end
    end

    // ****************************************
    // conversion sequencing
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_ff           <= '0;
            previous_result_ff  <= '0;
            pair_ff             <= 1'b0;
            clear_pend_ff       <= 1'b0;
            sample_count_ff     <= '0;
            precharge_active_ff <= 1'b0;
            threshold_strobe_ff <= 1'b0;
        end else begin
            clear_pend_ff       <= accumulate_ctrl_ff[accumulator_clear_bit] && !clear_pend_ff;
            threshold_strobe_ff <= nxt_strobe;
            // previous is taken at start, before this conversion's result lands
            if (conv_start) begin
                precharge_active_ff <= (precharge_time_ff != 8'h00);
                previous_result_ff  <= previous_sample_source ? filtered_value
                                     : {{(data_w-10){1'b0}}, result_ff};
            end else if (conv_done) begin
                precharge_active_ff <= 1'b0;
            end
            if (conv_done) begin
                result_ff <= conversion_result;
                pair_ff   <= nxt_pair;
            end
            if (clear_pend_ff) begin
                sample_count_ff <= '0;
            end else if (conv_done) begin
                sample_count_ff <= sample_count_ff + 8'h01;
            end
        end
    end

    adc_accum_unit #(
        .data_w(data_w)
    ) u_accum (
        .pclk           (pclk),
        .presetn        (presetn),
        .clear          (clear_pend_ff),
        .sample_done    (conv_done),
        .second_of_pair (pair_ff),
        .pair_mode      (double_sample_enable),
        .mode           (operating_mode_select),
        .right_shift    (accum_right_shift),
        .sample         (conversion_result),
        .prev_sample    (previous_result_ff[9:0]),
        .accum_ff       (accum_value),
        .filter_ff      (filtered_value),
        .overflow_ff    (accumulator_overflow)
    );

    // ****************************************
    // read mux
    // ****************************************
    // reads have no side effects, so the mux may follow paddr in any phase
    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            sampling_ctrl_addr:   prdata = {24'h0, sampling_ctrl_ff};
            accumulate_ctrl_addr: prdata = {24'h0, accumulate_ctrl_ff};
            // status packs the sample count above the pair phase and overflow
            status_addr:          prdata = {22'h0, sample_count_ff, pair_ff,
                                            accumulator_overflow};
            accum_addr:           prdata = {{(32-data_w){1'b0}}, accum_value};
            prev_addr:            prdata = {{(32-data_w){1'b0}}, previous_result_ff};
            filter_addr:          prdata = {{(32-data_w){1'b0}}, filtered_value};
            result_addr:          prdata = {22'h0, result_ff};
            precharge_time_addr:  prdata = {24'h0, precharge_time_ff};
            default:              prdata = 32'h0000_0000;
        endcase
    end
endmodule : adc_precharge_accum_config

/* File: verification/adc_precharge_accum_config_assertions.sv */
`timescale 1ns/1ns
// ****************
// port checks
// ****************
module adc_precharge_accum_config_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        conv_start,
    input wire logic        conv_done,
    input wire logic        precharge_active,
    input wire logic        pin_to_avdd,
    input wire logic        pin_to_vss,
    input wire logic        hold_capacitor_to_avdd,
    input wire logic        hold_capacitor_to_vss,
    input wire logic        guard_ring_level,
    input wire logic        threshold_calc_strobe,
    input wire logic        second_of_pair
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_second_done;
        second_of_pair && conv_done;
    endsequence
    a_unmapped_zero: assert property (
        psel && !pwrite && paddr > 12'h01c |-> prdata == 32'h0 && !pslverr)
        else $error("unmapped read not zero");
    a_pin_hold_pair: assert property (precharge_active |-> (pin_to_avdd ^ pin_to_vss) &&
        pin_to_avdd == hold_capacitor_to_vss && pin_to_vss == hold_capacitor_to_avdd)
        else $error("pin and hold levels not opposite");
    a_idle_no_short: assert property (!precharge_active |->
        !(pin_to_avdd || pin_to_vss || hold_capacitor_to_avdd || hold_capacitor_to_vss))
        else $error("short outside precharge");
    a_precharge_rise: assert property ($rose(precharge_active) |-> $past(conv_start))
        else $error("precharge without start");
    a_strobe_cause: assert property (
        threshold_calc_strobe |-> $past(conv_done) && !second_of_pair)
        else $error("threshold strobe mid pair");
    a_pair_done: assert property (s_second_done |=> threshold_calc_strobe && !second_of_pair)
        else $error("pair end without strobe");
    a_pair_toggle: assert property (
        $changed(second_of_pair) |-> $past(conv_done) || $past(psel && pwrite))
        else $error("pair phase moved without cause");
    a_guard_steady: assert property (
        !$past(psel && pwrite) && $stable(second_of_pair) |-> $stable(guard_ring_level))
        else $error("guard level moved without cause");
endmodule : adc_precharge_accum_config_assertions
bind adc_precharge_accum_config adc_precharge_accum_config_assertions u_chk (.pclk, .presetn,
    .psel, .pwrite, .paddr, .prdata, .pslverr, .conv_start, .conv_done, .precharge_active,
    .pin_to_avdd, .pin_to_vss, .hold_capacitor_to_avdd, .hold_capacitor_to_vss,
    .guard_ring_level, .threshold_calc_strobe, .second_of_pair);

/* File: verification/adc_precharge_accum_config_bench.sv */
`timescale 1ns/1ns
module adc_precharge_accum_config_bench;
    import adc_cfg_pkg::*;
    // ****************
    // stimulus and checks
    // ****************
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        conv_start = 1'b0, conv_done = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [9:0]  conversion_result = 10'h000;
    logic        pready, pslverr, precharge_active, pin_to_avdd, pin_to_vss, guard_ring_level;
    logic        hold_capacitor_to_avdd, hold_capacitor_to_vss;
    logic        threshold_calc_strobe, second_of_pair;
    wire  [7:0]  pins = {threshold_calc_strobe, second_of_pair, precharge_active, pin_to_avdd,
                         pin_to_vss, hold_capacitor_to_avdd, hold_capacitor_to_vss, guard_ring_level};
    int          bad_count = 0, total_checks = 0;

    adc_precharge_accum_config i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .conv_start, .conv_done, .conversion_result,
        .precharge_active, .pin_to_avdd, .pin_to_vss, .hold_capacitor_to_avdd,
        .hold_capacitor_to_vss, .guard_ring_level, .threshold_calc_strobe, .second_of_pair);

    initial begin
        forever #20 pclk = ~pclk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    // wait is bounded: a slave that never answers ends the run
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            check(32'h0, 32'h1, "apb timeout");
            results();
        end
        rdata = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(a, 1'b0, 32'h0);
        check(rdata, exp, what);
    endtask : rd

    task automatic conv(input logic s, input logic [9:0] r);
        @(posedge pclk);
        conv_start        <= s;
        conv_done         <= !s;
        conversion_result <= r;
        @(posedge pclk);
        conv_start <= 1'b0;
        conv_done  <= 1'b0;
        #1;
    endtask : conv

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(sampling_ctrl_addr, 32'h0, "sampling reset");
        rd(accumulate_ctrl_addr, 32'h0, "accumulate reset");
        apb(sampling_ctrl_addr, 1'b1, 32'hffff_ffff);
        rd(sampling_ctrl_addr, 32'he1, "unimplemented bits");
        rd(12'h100, 32'h0, "unmapped read");
        for (int m = 0; m < 8; m++) begin
            apb(accumulate_ctrl_addr, 1'b1, 32'h50 | m);
            rd(accumulate_ctrl_addr, 32'h50 | (m > 4 ? 4 : m), "mode code");
        end
        apb(accumulate_ctrl_addr, 1'b1, 32'h64);
        rd(accumulate_ctrl_addr, 32'h54, "reserved shift");
        $display("test registers done");
        apb(precharge_time_addr, 1'b1, 32'h0);
        apb(sampling_ctrl_addr, 1'b1, 32'h80);
        conv(1'b1, 10'h0);
        check(pins, 8'h00, "zero precharge time");
        conv(1'b0, 10'h0);
        apb(precharge_time_addr, 1'b1, 32'h05);
        // inversion bit set with pairing off must change nothing
        for (int p = 0; p < 4; p++) begin
            apb(sampling_ctrl_addr, 1'b1, {24'h0, p[1], 1'b1, p[0], 5'h0});
            conv(1'b1, 10'h0);
            check(pins, {3'b001, p[1], !p[1], !p[1], p[1], p[0]}, "precharge");
            conv(1'b0, 10'h0);
            check(pins, {7'h40, p[0]}, "single conversion end");
        end
        $display("test single done");
        for (int inv = 0; inv < 2; inv++) begin
            apb(sampling_ctrl_addr, 1'b1, inv ? 32'he1 : 32'ha1);
            conv(1'b1, 10'h0);
            check(pins, 8'h33, "first of pair");
            conv(1'b0, 10'h0);
            check(pins, inv ? 8'h40 : 8'h41, "between pair");
            conv(1'b1, 10'h0);
            check(pins, inv ? 8'h6c : 8'h73, "second of pair");
            conv(1'b0, 10'h0);
            check(pins, 8'h81, "pair end");
        end
        $display("test pair done");
        apb(accumulate_ctrl_addr, 1'b1, 32'h09);
        repeat (2) @(posedge pclk);
        rd(accumulate_ctrl_addr, 32'h01, "clear bit self clears");
        rd(accum_addr, 32'h0, "accumulator cleared");
        rd(status_addr, 32'h0, "count and overflow cleared");
        conv(1'b1, 10'h0);
        conv(1'b0, 10'h123);
        conv(1'b1, 10'h0);
        conv(1'b0, 10'h045);
        rd(prev_addr, 32'h123, "previous from result");
        rd(accum_addr, 32'h123, "pair second adds");
        conv(1'b1, 10'h0);
        conv(1'b0, 10'h010);
        rd(accum_addr, 32'h0de, "pair first subtracts");
        apb(accumulate_ctrl_addr, 1'b1, 32'h81);
        conv(1'b1, 10'h0);
        rd(prev_addr, 32'h0de, "previous from filter");
        conv(1'b0, 10'h0);
        $display("test accumulate done");
        apb(sampling_ctrl_addr, 1'b1, 32'h0);
        apb(accumulate_ctrl_addr, 1'b1, 32'h1c);
        repeat (2) @(posedge pclk);
        for (int k = 0; k < 2; k++) begin
            conv(1'b1, 10'h0);
            conv(1'b0, 10'h100);
        end
        rd(accum_addr, 32'h180, "low pass accumulator");
        rd(filter_addr, 32'h0c0, "low pass filtered");
        rd(status_addr, 32'h8, "sample count");
        $display("test low pass done");
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd(accumulate_ctrl_addr, 32'h0, "accumulate after reset");
        rd(accum_addr, 32'h0, "accumulator after reset");
        $display("test reset done");
        results();
    end
endmodule : adc_precharge_accum_config_bench
